// ==== rtl/stn_panel_display_controller.sv ====
// Panel display controller: register slave, fetch, timing and pins
`timescale 1ns/1ps
module stn_panel_display_controller #(
	parameter int ADDR_W = 15   // Display buffer address width
) (
	input  wire logic              core_clk,      // Core clock
	input  wire logic              reset,         // Async reset, high
	input  wire logic [7:0]        s_axi_awaddr,  // Write address
	input  wire logic              s_axi_awvalid, // Write addr valid
	output logic                   s_axi_awready, // Write addr ready
	input  wire logic [31:0]       s_axi_wdata,   // Write data
	input  wire logic [3:0]        s_axi_wstrb,   // Byte enables
	input  wire logic              s_axi_wvalid,  // Write data valid
	output logic                   s_axi_wready,  // Write data ready
	output logic [1:0]             s_axi_bresp,   // Write response
	output logic                   s_axi_bvalid,  // Write resp valid
	input  wire logic              s_axi_bready,  // Write resp ready
	input  wire logic [7:0]        s_axi_araddr,  // Read address
	input  wire logic              s_axi_arvalid, // Read addr valid
	output logic                   s_axi_arready, // Read addr ready
	output logic [31:0]            s_axi_rdata,   // Read data
	output logic [1:0]             s_axi_rresp,   // Read response
	output logic                   s_axi_rvalid,  // Read data valid
	input  wire logic              s_axi_rready,  // Read data ready
	input  wire logic              display_clock, // Display clock pin
	output logic                   mem_rd,        // Buffer read strobe
	output logic [ADDR_W-1:0]      mem_addr,      // Buffer address
	input  wire logic [7:0]        mem_rdata,     // Data, next cycle
	input  wire logic [10:0]       shared_port_out_value, // Port values
	output logic                   frame_marker,     // Frame marker
	output logic                   line_latch_pulse, // Line latch
	output logic                   gray_line_pulse,  // Second line pulse
	output logic                   polarity_alt_out, // Polarity alt
	output logic                   shift_clock_out,  // Shift clock
	output logic [7:0]             pixel_data_bus,   // Pixel data
	output logic                   converter_power_out, // Power on
	output logic                   contrast_out      // Contrast PWM
);

	if (ADDR_W < 10 || ADDR_W > 16) begin : g_chk
		$error("ADDR_W out of range");
	end

	typedef enum logic [1:0] {
		F_IDLE = 2'b00,
		F_WAIT = 2'b01
	} fetch_t;

	typedef struct packed {
		logic                 awready;
		logic                 wready;
		logic                 bvalid;
		logic                 arready;
		logic                 rvalid;
		logic                 aw_got;
		logic                 w_got;
		logic [7:0]           waddr;
		logic [31:0]          wdata;
		logic [3:0]           wstrb;
		logic [1:0]           bresp;
		logic [1:0]           rresp;
		logic [31:0]          rdata;
		logic [7:0]           ctrl;
		logic [7:0]           clkc;
		logic [7:0]           pal;
		logic [5:0]           contrast;
		logic [10:0]          width;
		logic [9:0]           height;
		logic [9:0]           vwidth;
		logic [ADDR_W-1:0]    base;
		logic [4:0]           acper;
		logic                 clk_s1;
		logic                 clk_s2;
		logic                 clk_d;
		fetch_t               st;
		logic [7:0]           byte_v;
		logic [3:0]           left;
		logic [3:0]           dots;
		logic [7:0]           word;
		logic                 rdy;
		logic                 mem_rd;
		logic [ADDR_W-1:0]    addr;
		logic [ADDR_W-1:0]    line_addr;
		logic [10:0]          pix;
		logic [9:0]           line;
		logic [4:0]           ac_cnt;
		logic [4:0]           phase;
		logic                 pend;
		logic                 pend_last;
		display_pkg::panel_t  pan;
		display_pkg::panel_t  pins;
		logic                 pwr;
	} state_t;

	localparam state_t S_RST = '{
		ctrl:     display_pkg::CTRL_RST,
		clkc:     display_pkg::CLKC_RST,
		pal:      display_pkg::PALETTE_RST,
		contrast: display_pkg::CONTRAST_RST,
		width:    display_pkg::WIDTH_RST,
		height:   display_pkg::HEIGHT_RST,
		vwidth:   display_pkg::VWIDTH_RST,
		base:     ADDR_W'(display_pkg::BASE_RST),
		acper:    display_pkg::ACPER_RST,
		st:       F_IDLE,
		default:  '0
	};

	state_t s;
	state_t n;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] b);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (b[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Dots moved per shift clock, from the bus width field
	function automatic logic [3:0] bus_dots(input logic [7:0] c);
		case (c[display_pkg::CLKC_BUSW +: 2])
			display_pkg::BUS_1: return 4'h1;
			display_pkg::BUS_4: return 4'h4;
			default:            return 4'h8;
		endcase
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic        tick;
		logic        ld;
		logic        lend;
		logic        last;
		logic        off;
		logic        dot;
		logic [4:0]  lvl;
		logic [3:0]  bw;
		logic [3:0]  bpp;
		logic [1:0]  p2;
		logic [10:0] half;
		logic [10:0] npix;
		tick = 1'b0;
		ld   = 1'b0;
		lend = 1'b0;
		last = 1'b0;
		off  = 1'b0;
		dot  = 1'b0;
		lvl  = '0;
		bw   = '0;
		bpp  = '0;
		p2   = '0;
		half = '0;
		npix = '0;
		n = s;
		n.mem_rd = 1'b0;

		// Register slave, write side
		if (s_axi_awvalid && s.awready) begin
			n.aw_got = 1'b1;
			n.waddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready) begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (s.aw_got && s.w_got && !s.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got  = 1'b0;
			n.bvalid = 1'b1;
			n.bresp  = display_pkg::RESP_OKAY;
			case (s.waddr)
				display_pkg::OFS_CTRL:
					n.ctrl = 8'(merge(32'(s.ctrl), s.wdata, s.wstrb));
				display_pkg::OFS_CLKC:
					n.clkc = 8'(merge(32'(s.clkc), s.wdata, s.wstrb));
				display_pkg::OFS_CONTRAST:
					n.contrast = 6'(merge(32'(s.contrast), s.wdata,
						s.wstrb));
				display_pkg::OFS_PALETTE:
					n.pal = 8'(merge(32'(s.pal), s.wdata, s.wstrb));
				display_pkg::OFS_WIDTH:
					n.width = 11'(merge(32'(s.width), s.wdata, s.wstrb));
				display_pkg::OFS_HEIGHT:
					n.height = 10'(merge(32'(s.height), s.wdata,
						s.wstrb));
				display_pkg::OFS_VWIDTH:
					n.vwidth = 10'(merge(32'(s.vwidth), s.wdata,
						s.wstrb));
				display_pkg::OFS_BASE:
					n.base = ADDR_W'(merge(32'(s.base), s.wdata,
						s.wstrb));
				display_pkg::OFS_ACPER:
					n.acper = 5'(merge(32'(s.acper), s.wdata, s.wstrb));
				display_pkg::OFS_STATUS: n.bresp = display_pkg::RESP_OKAY;
				default: n.bresp = display_pkg::RESP_SLVERR;
			endcase
		end
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		n.awready = !n.aw_got && !n.bvalid;
		n.wready  = !n.w_got && !n.bvalid;

		// Register slave, read side
		if (s_axi_arvalid && s.arready) begin
			n.rvalid = 1'b1;
			n.rresp  = display_pkg::RESP_OKAY;
			case (s_axi_araddr)
				display_pkg::OFS_CTRL:     n.rdata = 32'(s.ctrl);
				display_pkg::OFS_CLKC:     n.rdata = 32'(s.clkc);
				display_pkg::OFS_CONTRAST: n.rdata = 32'(s.contrast);
				display_pkg::OFS_PALETTE:  n.rdata = 32'(s.pal);
				display_pkg::OFS_WIDTH:    n.rdata = 32'(s.width);
				display_pkg::OFS_HEIGHT:   n.rdata = 32'(s.height);
				display_pkg::OFS_VWIDTH:   n.rdata = 32'(s.vwidth);
				display_pkg::OFS_BASE:     n.rdata = 32'(s.base);
				display_pkg::OFS_ACPER:    n.rdata = 32'(s.acper);
				display_pkg::OFS_STATUS:
					n.rdata = 32'({s.pan.ac, s.pan.fm, s.phase, s.line});
				default: begin
					n.rdata = '0;
					n.rresp = display_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		n.arready = !n.rvalid;

		// Display clock pin: two flops, then edge find
		n.clk_s1 = display_clock;
		n.clk_s2 = s.clk_s1;
		n.clk_d  = s.clk_s2;
		tick = s.clk_s2 && !s.clk_d;
		off  = s.ctrl[display_pkg::CTRL_OFF];
		bw   = bus_dots(s.clkc);
		bpp  = s.ctrl[display_pkg::CTRL_G16] ? 4'h4 :
			(s.ctrl[display_pkg::CTRL_G4] ? 4'h2 : 4'h1);

		// Fetch and dot assembly run between shift clock loads
		case (s.st)
			F_IDLE: begin
				if (!s.rdy && s.left == '0) begin
					n.mem_rd = 1'b1;
					n.st     = F_WAIT;
				end else if (!s.rdy) begin
					// Leftmost pixel sits in the top bits of the byte
					p2 = s.byte_v[7:6];
					case (bpp)
						4'h4: lvl = {s.byte_v[7:4], s.byte_v[7]};
						4'h2: lvl = {s.pal[{p2, 1'b0} +: 2],
							s.pal[{p2, 1'b0} +: 2], s.pal[{p2, 1'b0} + 1]};
						default: lvl = s.byte_v[7] ? 5'h1f : 5'h00;
					endcase
					// Frame-rate control spreads a level over frames
					dot = s.ctrl[display_pkg::CTRL_FRC] ?
						(lvl > s.phase) : lvl[4];
					n.word   = {s.word[6:0], dot};
					n.byte_v = s.byte_v << bpp;
					n.left   = s.left - bpp;
					n.dots   = s.dots + 4'h1;
					n.rdy    = (s.dots + 4'h1 == bw);
				end
			end
			F_WAIT: begin
				// Strobe cycle first; the buffer answers the cycle after
				if (!s.mem_rd) begin
					n.byte_v = mem_rdata;
					n.left   = 4'h8;
					n.addr   = s.addr + 1'b1;
					n.st     = F_IDLE;
				end
			end
			default: n.st = F_IDLE;
		endcase

		// Shift clock; new data goes out on its rising edge so the
		// panel sees it settled at the falling edge
		if (tick) begin
			n.pan.sclk = !s.pan.sclk;
			n.pan.lp   = 1'b0;
			n.pan.lp2  = 1'b0;
		end
		ld   = tick && !s.pan.sclk;
		npix = s.pix + 11'(bw);
		half = s.width >> 1;
		lend = ld && (npix >= s.width);
		// At or past the end, so a smaller height still wraps at once
		last = (s.line >= s.height - 10'h1);
		if (ld) begin
			n.pan.data = s.ctrl[display_pkg::CTRL_INV] ?
				~s.word : s.word;
			n.rdy  = 1'b0;
			n.dots = '0;
			n.word = '0;
			n.pix  = npix;
			if (s.ctrl[display_pkg::CTRL_PWM] && s.pix < half &&
				npix >= half) begin
				n.pan.lp2 = 1'b1;
			end
		end
		if (lend) begin
			n.pix    = '0;
			n.left   = '0;
			// Latch waits until the last word has been shifted in
			n.pend      = 1'b1;
			n.pend_last = last;
			if (last) begin
				n.line      = '0;
				n.line_addr = s.base;
				n.addr      = s.base;
				n.phase = (s.phase == display_pkg::FRC_LAST) ?
					'0 : s.phase + 5'h1;
			end else begin
				// Virtual page width steps between stored lines
				n.line      = s.line + 10'h1;
				n.line_addr = s.line_addr + ADDR_W'(s.vwidth);
				n.addr      = s.line_addr + ADDR_W'(s.vwidth);
			end
		end
		// Pulses go out one cycle after the falling shift edge
		if (s.pend && !s.pan.sclk && !tick) begin
			n.pend    = 1'b0;
			n.pan.lp  = 1'b1;
			n.pan.lp2 = !s.ctrl[display_pkg::CTRL_PWM];
			n.pan.fm  = s.pend_last;
			if (s.acper == '0) begin
				n.pan.ac = s.pan.ac ^ s.pend_last;
			end else if (s.ac_cnt + 5'h1 >= s.acper) begin
				n.ac_cnt = '0;
				n.pan.ac = !s.pan.ac;
			end else begin
				n.ac_cnt = s.ac_cnt + 5'h1;
			end
		end

		// Pins: when off, the shared port values take over, lp2 and sclk held low
		n.pwr = !off;
		if (off) begin
			n.pins.fm   = shared_port_out_value[6];
			n.pins.lp   = shared_port_out_value[5];
			n.pins.ac   = shared_port_out_value[4];
			n.pins.lp2  = 1'b0;
			n.pins.sclk = 1'b0;
			n.pins.data = {shared_port_out_value[10:7],
				shared_port_out_value[3:0]};
		end else begin
			n.pins = s.pan;
			case (bw)
				4'h1: n.pins.data = {shared_port_out_value[10:7],
					shared_port_out_value[3:1], s.pan.data[0]};
				4'h4: n.pins.data = {shared_port_out_value[10:7],
					s.pan.data[3:0]};
				default: n.pins.data = s.pan.data;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			s <= S_RST;
		end else begin
			s <= n;
		end
	end

	contrast_pwm #(
		.CNT_W (6)
	) u_contrast (
		.core_clk     (core_clk),
		.reset        (reset),
		.step         (s.clk_s2 && !s.clk_d),
		.level        (s.contrast),
		.dark         (s.ctrl[display_pkg::CTRL_DARK]),
		.contrast_out (contrast_out)
	);

	assign s_axi_awready       = s.awready;
	assign s_axi_wready        = s.wready;
	assign s_axi_bvalid        = s.bvalid;
	assign s_axi_bresp         = s.bresp;
	assign s_axi_arready       = s.arready;
	assign s_axi_rvalid        = s.rvalid;
	assign s_axi_rresp         = s.rresp;
	assign s_axi_rdata         = s.rdata;
	assign mem_rd              = s.mem_rd;
	assign mem_addr            = s.addr;
	assign frame_marker        = s.pins.fm;
	assign line_latch_pulse    = s.pins.lp;
	assign gray_line_pulse     = s.pins.lp2;
	assign polarity_alt_out    = s.pins.ac;
	assign shift_clock_out     = s.pins.sclk;
	assign pixel_data_bus      = s.pins.data;
	assign converter_power_out = s.pwr;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	pwr_follow_a: assert property (
		##1 converter_power_out == !$past(s.ctrl[display_pkg::CTRL_OFF]))
		else $error("power output does not follow display off");
	fm_rise_a: assert property (
		$rose(s.pan.fm) |-> $rose(s.pan.lp) && s.line == '0)
		else $error("frame marker rose away from last latch");
	fm_fall_a: assert property (
		$fell(s.pan.fm) |-> $rose(s.pan.lp))
		else $error("frame marker fell away from a latch");
	lp_short_a: assert property (
		$rose(s.pan.lp) |-> ##[1:1000] !s.pan.lp)
		else $error("line latch pulse stuck high");
	ac_at_line_a: assert property (
		$changed(s.pan.ac) |-> $rose(s.pan.lp))
		else $error("polarity changed outside a line end");
	dark_low_a: assert property (
		s.ctrl[display_pkg::CTRL_DARK] |=> !contrast_out)
		else $error("contrast output high while forced dark");
	level_zero_a: assert property (
		!s.ctrl[display_pkg::CTRL_DARK] && s.contrast == '0
		|=> contrast_out)
		else $error("contrast output low at level zero");
	off_port_a: assert property (
		s.ctrl[display_pkg::CTRL_OFF] |=>
		frame_marker == $past(shared_port_out_value[6]) &&
		!shift_clock_out)
		else $error("pins not handed to port while off");
	lp2_copy_a: assert property (
		!s.ctrl[display_pkg::CTRL_OFF] &&
		!s.ctrl[display_pkg::CTRL_PWM] && !s.pan.lp2 && !s.pan.lp
		|=> gray_line_pulse == line_latch_pulse)
		else $error("second line pulse differs from latch");
	bus_one_a: assert property (
		!s.ctrl[display_pkg::CTRL_OFF] && s.clkc[5:4] == 2'b00 |=>
		pixel_data_bus[3:1] == $past(shared_port_out_value[3:1]))
		else $error("spare data pins not on port values");

	frame_c: cover property ($rose(frame_marker));
	ac_c: cover property ($changed(polarity_alt_out));
	write_c: cover property (s.bvalid && s_axi_bready);

endmodule

// ==== rtl/display_pkg.sv ====
// Register map, field layout and reset values of the panel display block
package display_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFS_CTRL     = 8'h40;
	localparam logic [7:0] OFS_CLKC     = 8'h44;
	localparam logic [7:0] OFS_CONTRAST = 8'h48;
	localparam logic [7:0] OFS_PALETTE  = 8'h4c;
	localparam logic [7:0] OFS_WIDTH    = 8'h50;
	localparam logic [7:0] OFS_HEIGHT   = 8'h54;
	localparam logic [7:0] OFS_VWIDTH   = 8'h58;
	localparam logic [7:0] OFS_BASE     = 8'h5c;
	localparam logic [7:0] OFS_ACPER    = 8'h60;
	localparam logic [7:0] OFS_STATUS   = 8'h64;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_OFF  = 7;
	localparam int CTRL_DARK = 6;
	localparam int CTRL_INV  = 5;
	localparam int CTRL_G16  = 3;
	localparam int CTRL_G4   = 2;
	localparam int CTRL_PWM  = 1;
	localparam int CTRL_FRC  = 0;
	localparam int CLKC_BUSW = 4;

	// ****************************************
	// Reset values and counts
	// ****************************************
	localparam logic [7:0]  CTRL_RST     = 8'h80;
	localparam logic [7:0]  CLKC_RST     = 8'h00;
	localparam logic [5:0]  CONTRAST_RST = 6'h00;
	localparam logic [7:0]  PALETTE_RST  = 8'he4;
	localparam logic [10:0] WIDTH_RST    = 11'h0a0;
	localparam logic [9:0]  HEIGHT_RST   = 10'h078;
	localparam logic [9:0]  VWIDTH_RST   = 10'h014;
	localparam logic [14:0] BASE_RST     = 15'h0000;
	localparam logic [4:0]  ACPER_RST    = 5'h00;
	localparam logic [4:0]  FRC_LAST     = 5'h1e;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef enum logic [1:0] {
		BUS_1 = 2'b00,
		BUS_4 = 2'b01,
		BUS_8 = 2'b10
	} bus_w_t;

	// Panel-side signal group
	typedef struct packed {
		logic       fm;
		logic       lp;
		logic       lp2;
		logic       ac;
		logic       sclk;
		logic [7:0] data;
	} panel_t;

endpackage

// ==== rtl/contrast_pwm.sv ====
// Contrast and blanking PWM generator
`timescale 1ns/1ps
module contrast_pwm #(
	parameter int CNT_W = 6     // Width of level and PWM counter
) (
	input  wire logic             core_clk,     // Core clock
	input  wire logic             reset,        // Async reset, high
	input  wire logic             step,         // One-cycle PWM step
	input  wire logic [CNT_W-1:0] level,        // Contrast level
	input  wire logic             dark,         // Force dark
	output logic                  contrast_out  // Contrast PWM pin
);

	if (CNT_W < 2 || CNT_W > 8) begin : g_chk
		$error("CNT_W out of range");
	end

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             out;
	} pwm_state_t;

	pwm_state_t s;
	pwm_state_t n;

	always_comb begin
		n = s;
		if (step) begin
			n.cnt = s.cnt + 1'b1;
		end
		// Higher level means shorter high time, lower contrast
		if (dark) begin
			n.out = 1'b0;
		end else if (level == '0) begin
			n.out = 1'b1;
		end else begin
			n.out = (s.cnt >= level);
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign contrast_out = s.out;

endmodule

// ==== testbench/panel_model.sv ====
// Behavioural segment and common driver pair seen by the controller
`timescale 1ns/1ps
module panel_model (
	input  wire logic       core_clk, // Core clock, edge finder
	input  wire logic       sclk,     // Shift clock pin
	input  wire logic       lp,       // Line latch pin
	input  wire logic       lp2,      // Second line pulse pin
	input  wire logic       fm,       // Frame marker pin
	input  wire logic       ac,       // Polarity pin
	input  wire logic [7:0] d,        // Pixel data pins
	output logic      [7:0] last_d,   // Last word shifted in
	output logic      [7:0] line_bits,// Last 8 bits before a latch
	output int              per_line, // Shifts in the last line
	output int              lpf,      // Latches in the last frame
	output logic            ac_tog,   // Polarity moved since latch
	output logic            lp2_diff  // Second pulse ever differed
);
	logic       sclk_q = 1'b0;
	logic       lp_q = 1'b0;
	logic       fm_q = 1'b0;
	logic       ac_last = 1'b0;
	logic [7:0] sr = 8'h00;
	int         cnt = 0;
	int         lines = 0;

	initial lp2_diff = 1'b0;
	always @(posedge core_clk) begin
		sclk_q <= sclk;
		lp_q <= lp;
		fm_q <= fm;
		if (lp2 !== lp)
			lp2_diff <= 1'b1;
		// Segment data enters the line buffer on the falling shift edge
		if (sclk_q && !sclk) begin
			last_d <= d;
			sr <= {sr[6:0], d[0]};
			cnt <= cnt + 1;
		end
		if (lp && !lp_q) begin
			line_bits <= sr;
			per_line <= cnt;
			cnt <= 0;
			ac_tog <= (ac !== ac_last);
			ac_last <= ac;
			// Marker still high from the frame end names the first line
			if (fm_q) begin
				lpf <= lines;
				lines <= 1;
			end else begin
				lines <= lines + 1;
			end
		end
	end
endmodule

// ==== testbench/stn_panel_display_controller_tb.sv ====
// Self-checking bench for the panel display controller
`timescale 1ns/1ps
module stn_panel_display_controller_tb;
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] e;
		logic [1:0]  r;
	} row_t;
	logic core_clk = 1'b0, reset = 1'b1, display_clock = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [7:0]  mem_rdata = 8'h00, mem_byte = 8'h96;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_d;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [10:0] shared_port_out_value = 11'h000;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, mem_rd, frame_marker, line_latch_pulse;
	logic gray_line_pulse, polarity_alt_out, shift_clock_out;
	logic converter_power_out, contrast_out, ac_tog, lp2_diff;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
	logic [14:0] mem_addr;
	logic [7:0]  pixel_data_bus, last_d, line_bits;
	int          per_line, lpf, hi, error_cnt = 0, n_tests = 0, cyc = 0;
	row_t rows [9] = '{'{8'h40, 32'h0000_0080, 2'h0},
		'{8'h44, 32'h0000_0000, 2'h0}, '{8'h48, 32'h0000_0000, 2'h0},
		'{8'h4c, 32'h0000_00e4, 2'h0}, '{8'h50, 32'h0000_00a0, 2'h0},
		'{8'h54, 32'h0000_0078, 2'h0}, '{8'h58, 32'h0000_0014, 2'h0},
		'{8'h70, 32'h0000_0000, 2'h2}, '{8'h41, 32'h0000_0000, 2'h2}};

	stn_panel_display_controller uut (.core_clk, .reset, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.display_clock, .mem_rd, .mem_addr, .mem_rdata,
		.shared_port_out_value, .frame_marker, .line_latch_pulse,
		.gray_line_pulse, .polarity_alt_out, .shift_clock_out,
		.pixel_data_bus, .converter_power_out, .contrast_out);
	panel_model panel (.core_clk, .sclk(shift_clock_out),
		.lp(line_latch_pulse), .lp2(gray_line_pulse), .fm(frame_marker),
		.ac(polarity_alt_out), .d(pixel_data_bus), .last_d, .line_bits,
		.per_line, .lpf, .ac_tog, .lp2_diff);

	initial forever #2 core_clk = ~core_clk;
	initial forever #62.5 display_clock = ~display_clock;
	// Buffer answers one cycle after the strobe, as the fetch expects
	always @(posedge core_clk) begin
		if (mem_rd)
			mem_rdata <= mem_byte;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			close_out();
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		repeat (50) begin
			@(posedge core_clk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1)
				break;
		end
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		repeat (50) begin
			@(posedge core_clk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1)
				break;
		end
		rd_d = s_axi_rdata;
		rd_r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic count_hi(input int n);
		hi = 0;
		repeat (n) begin
			@(posedge core_clk);
			hi += int'(contrast_out === 1'b1);
		end
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		repeat (3) @(posedge core_clk);
		chkb(converter_power_out, 1'b0);
		chkb(contrast_out, 1'b1);
		foreach (rows[i]) begin
			rd(rows[i].a);
			chk(rd_d, rows[i].e);
			chk({30'h0, rd_r}, {30'h0, rows[i].r});
		end
		$display("test registers done");
		// Off: pins show the port values, shift clock parked low
		shared_port_out_value <= 11'h45a;
		repeat (3) @(posedge core_clk);
		chk({24'h0, pixel_data_bus}, 32'h0000_008a);
		chkb(frame_marker, 1'b1);
		chkb(line_latch_pulse, 1'b0);
		chkb(polarity_alt_out, 1'b1);
		chkb(shift_clock_out, 1'b0);
		shared_port_out_value <= 11'h000;
		$display("test port values done");
		wr(8'h50, 32'h0000_0010);
		wr(8'h54, 32'h0000_0004);
		wr(8'h60, 32'h0000_0001);
		wr(8'h44, 32'h0000_0020);
		wr(8'h40, 32'h0000_0000);
		@(posedge core_clk);
		chkb(converter_power_out, 1'b1);
		repeat (10) @(posedge line_latch_pulse);
		repeat (3) @(posedge core_clk);
		chk(per_line, 32'h0000_0002);
		chk(lpf, 32'h0000_0004);
		chk({24'h0, last_d}, 32'h0000_0096);
		chkb(ac_tog, 1'b1);
		$display("test 8-bit stream done");
		wr(8'h40, 32'h0000_0020);
		repeat (4) @(posedge line_latch_pulse);
		chk({24'h0, last_d}, 32'h0000_0069);
		$display("test invert done");
		// 16-gray: nibbles 9 and 6 give dots 1 and 0
		wr(8'h40, 32'h0000_0008);
		repeat (4) @(posedge line_latch_pulse);
		chk({24'h0, last_d}, 32'h0000_00aa);
		// 4-gray: palette fields for 2,1,1,2 give dots 1,0,0,1
		wr(8'h40, 32'h0000_0004);
		repeat (4) @(posedge line_latch_pulse);
		chk({24'h0, last_d}, 32'h0000_0099);
		$display("test gray modes done");
		wr(8'h40, 32'h0000_0000);
		wr(8'h44, 32'h0000_0000);
		repeat (4) @(posedge line_latch_pulse);
		repeat (3) @(posedge core_clk);
		chk(per_line, 32'h0000_0010);
		chk({24'h0, line_bits}, 32'h0000_0096);
		$display("test 1-bit stream done");
		count_hi(200);
		chk(hi, 32'h0000_00c8);
		wr(8'h40, 32'h0000_0040);
		count_hi(200);
		chk(hi, 32'h0000_0000);
		wr(8'h40, 32'h0000_0000);
		wr(8'h48, 32'h0000_0020);
		count_hi(2000);
		// Half duty, allowing about three steps of tick jitter either way
		chkb(hi > 900 && hi < 1100, 1'b1);
		$display("test contrast done");
		chkb(lp2_diff, 1'b0);
		wr(8'h40, 32'h0000_0080);
		repeat (3) @(posedge core_clk);
		chkb(converter_power_out, 1'b0);
		$display("test power off done");
		close_out();
	end
endmodule
